/* test/abr_core_model.sv */
// Partner model: core register file and data memory address sink.
// Assumes the generator's write back and address strobe on one clock.
module abr_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench preload of one pointer
    input  wire logic        load_en,
    input  wire logic [3:0]  load_idx,
    input  wire logic [15:0] load_val,
    // Write back and address from the generator
    input  wire logic        wb_en,
    input  wire logic [3:0]  wb_reg,
    input  wire logic [15:0] wb_data,
    input  wire logic        ea_valid,
    input  wire logic [15:0] ea_addr,
    // Pointer file and memory view for the bench
    output logic [15:0]      ptr_file_reg [16],
    output logic [15:0]      last_ea_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    // Write back lands at the edge after the pulse, as a real file would
    always_ff @(posedge clk) begin
        if (rst) begin
            last_ea_reg <= 16'h0000;
        end else begin
            if (load_en) ptr_file_reg[load_idx] <= load_val;
            if (wb_en) ptr_file_reg[wb_reg] <= wb_data;
            if (ea_valid) last_ea_reg <= ea_addr;
        end
    end
endmodule

/* test/tb_agu_bit_reverse_modulo.sv */
// Self-checking bench: APB setup, then core requests with expected results.
// Assumes abr_regs.svh, abr_pkg, abr_agu and abr_core_model are compiled.
`include "abr_regs.svh"
module tb_agu_bit_reverse_modulo;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and APB master signals
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    // Core request and generator outputs
    logic req_valid, req_write, req_byte, ea_valid, ea_write, rev_active, wb_en;
    abr_pkg::abr_mode_t req_mode;
    logic [3:0] req_wreg, wb_reg, load_idx;
    logic [15:0] req_ptr, req_offs, ea_addr, wb_data, load_val, last_ea;
    logic [15:0] ptr_file [16];
    logic load_en, err;
    int n_errors, num_checks;
    abr_agu i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .req_valid(req_valid), .req_write(req_write), .req_byte(req_byte),
        .req_mode(req_mode), .req_wreg(req_wreg), .req_ptr(req_ptr), .req_offs(req_offs),
        .ea_valid(ea_valid), .ea_write(ea_write), .ea_addr(ea_addr),
        .rev_active(rev_active), .wb_en(wb_en), .wb_reg(wb_reg), .wb_data(wb_data));
    abr_core_model i_core (.clk(clk), .rst(rst), .load_en(load_en), .load_idx(load_idx),
        .load_val(load_val), .wb_en(wb_en), .wb_reg(wb_reg), .wb_data(wb_data),
        .ea_valid(ea_valid), .ea_addr(ea_addr), .ptr_file_reg(ptr_file),
        .last_ea_reg(last_ea));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Closing verdict, shared by the tests and the watchdog
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 8);
        rd = prdata;
        err = pslverr;
        if (k >= 8) chk(1'b0, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Register read with expected data and error flag
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] e, input logic e_err);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
        chk(err, e_err);
    endtask
    // One core request, then compare every generator output
    task automatic step(input logic wr, input logic by, input abr_pkg::abr_mode_t md,
        input logic [3:0] r, input logic [15:0] p, input logic [15:0] of,
        input logic [15:0] e_ea, input logic e_wb, input logic [15:0] e_wd, input logic e_rv);
        int k = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_byte <= by;
        req_mode <= md;
        req_wreg <= r;
        req_ptr <= p;
        req_offs <= of;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        // Bounded wait for the address strobe
        while (ea_valid !== 1'b1 && k < 4) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(ea_valid, 1'b1);
        chk(ea_addr, e_ea);
        chk(ea_write, wr);
        chk(rev_active, e_rv);
        chk(wb_en, e_wb);
        if (e_wb) chk({wb_reg, wb_data}, {r, e_wd});
    endtask
    // Four-bit index reversal for the expected sequence
    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction
    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, req_valid, req_write, req_byte, load_en} = 8'h80;
        {paddr, pwdata, req_wreg, req_ptr, req_offs, load_idx, load_val} = '0;
        req_mode = abr_pkg::AM_IND;
        n_errors = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values, mask, read-only and unmapped places
        reg_rd(`ABR_OFS_MODCTL, 32'h0000_00F0, 1'b0);
        reg_rd(`ABR_OFS_BRCFG, 32'h0000_0000, 1'b0);
        reg_rd(`ABR_OFS_LASTEA, 32'h0000_0000, 1'b0);
        reg_rd(12'h020, 32'h0000_0000, 1'b1);
        apb(1'b1, `ABR_OFS_MODCTL, 32'h0000_FFFF);
        reg_rd(`ABR_OFS_MODCTL, 32'h0000_80FF, 1'b0);
        apb(1'b1, `ABR_OFS_BRCFG, 32'h0000_FFFF);
        reg_rd(`ABR_OFS_BRCFG, 32'h0000_FFFF, 1'b0);
        $display("test registers done");
        // Modulo buffer 0x0100..0x010F on several pointers
        apb(1'b1, `ABR_OFS_BRCFG, 32'h0000_0000);
        apb(1'b1, `ABR_OFS_MODSTART, 32'h0000_0100);
        apb(1'b1, `ABR_OFS_MODEND, 32'h0000_010F);
        for (int r = 0; r < 16; r += 7) begin
            apb(1'b1, `ABR_OFS_MODCTL, 32'h0000_80F0 | r);
            step(0, 0, abr_pkg::AM_POSTINC, r, 16'h010E, 2, 16'h010E, 1, 16'h0100, 0);
        end
        apb(1'b1, `ABR_OFS_MODCTL, 32'h0000_80F3);
        step(1, 0, abr_pkg::AM_PREINC, 3, 16'h010E, 4, 16'h0102, 1, 16'h0102, 0);
        step(0, 0, abr_pkg::AM_PREDEC, 3, 16'h0100, 2, 16'h010E, 1, 16'h010E, 0);
        step(0, 0, abr_pkg::AM_POSTDEC, 3, 16'h0100, 4, 16'h0100, 1, 16'h010C, 0);
        step(0, 0, abr_pkg::AM_REGOFS, 3, 16'h010C, 6, 16'h0102, 0, 16'h0000, 0);
        step(0, 0, abr_pkg::AM_REGOFS, 3, 16'h0102, 16'hFFFC, 16'h010E, 0, 16'h0000, 0);
        step(0, 0, abr_pkg::AM_IND, 3, 16'h0120, 2, 16'h0120, 0, 16'h0000, 0);
        step(0, 0, abr_pkg::AM_POSTINC, 5, 16'h010E, 2, 16'h010E, 1, 16'h0110, 0);
        reg_rd(`ABR_OFS_LASTEA, 32'h0000_010E, 1'b0);
        $display("test modulo done");
        // Reversal on pointer 2 with modulo also enabled on it
        apb(1'b1, `ABR_OFS_MODSTART, 32'h0000_0200);
        apb(1'b1, `ABR_OFS_MODEND, 32'h0000_0207);
        apb(1'b1, `ABR_OFS_MODCTL, 32'h0000_8022);
        apb(1'b1, `ABR_OFS_BRCFG, 32'h0000_8008);
        @(posedge clk);
        load_en <= 1'b1;
        load_idx <= 4'h2;
        load_val <= 16'h0200;
        @(posedge clk);
        load_en <= 1'b0;
        // Sixteen post-increments, pointer fed back through the core file
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            #1;
            step(1, 0, abr_pkg::AM_POSTINC, 2, ptr_file[2], 6, 16'h0200 | {rev4(4'(i)), 1'b0},
                 1'b1, 16'h0200 | {rev4(4'(i + 1)), 1'b0}, 1);
        end
        step(1, 0, abr_pkg::AM_PREINC, 2, 16'h0200, 6, 16'h0210, 1, 16'h0210, 1);
        step(1, 0, abr_pkg::AM_POSTINC, 2, 16'h0201, 2, 16'h0200, 1, 16'h0210, 1);
        step(0, 0, abr_pkg::AM_POSTINC, 2, 16'h0206, 2, 16'h0206, 1, 16'h0200, 0);
        step(1, 1, abr_pkg::AM_POSTINC, 2, 16'h0204, 1, 16'h0204, 1, 16'h0205, 0);
        step(1, 0, abr_pkg::AM_PREDEC, 2, 16'h0204, 2, 16'h0202, 1, 16'h0202, 0);
        step(1, 0, abr_pkg::AM_IND, 2, 16'h0204, 2, 16'h0204, 0, 16'h0000, 0);
        step(1, 0, abr_pkg::AM_POSTINC, 4, 16'h0204, 2, 16'h0204, 1, 16'h0206, 0);
        $display("test reverse done");
        // Reverse enable, then pointer select (15), removed in turn
        apb(1'b1, `ABR_OFS_BRCFG, 32'h0000_0008);
        step(1, 0, abr_pkg::AM_POSTINC, 2, 16'h0200, 2, 16'h0200, 1, 16'h0202, 0);
        apb(1'b1, `ABR_OFS_MODCTL, 32'h0000_00F0);
        apb(1'b1, `ABR_OFS_BRCFG, 32'h0000_8008);
        step(1, 0, abr_pkg::AM_POSTINC, 15, 16'h0200, 2, 16'h0200, 1, 16'h0202, 0);
        // Widest modifier
        apb(1'b1, `ABR_OFS_MODCTL, 32'h0000_0020);
        apb(1'b1, `ABR_OFS_BRCFG, 32'h0000_C000);
        reg_rd(`ABR_OFS_BRCFG, 32'h0000_C000, 1'b0);
        step(1, 0, abr_pkg::AM_PREINC, 2, 16'h0000, 2, 16'h8000, 1, 16'h8000, 1);
        // Memory side latches the address one edge after the strobe
        @(posedge clk);
        #1;
        chk(last_ea, 16'h8000);
        $display("test conditions done");
        tally_and_finish();
    end
endmodule

/* verilog/abr_agu.sv */
// Data address generator with modulo and bit-reversed addressing.
// Assumes an APB master for setup and one core request per clock.
//
// Overview of operation
// RULE_01: Modulo applies to any working register pointer
// RULE_02: Boundary test catches addresses beyond the bound
// RULE_03: Write back only for pre or post modify
// RULE_04: Register-plus-offset corrects but keeps pointer unchanged
// RULE_05: Bit reversal only on X write data path
// RULE_06: Only the modifier is taken bit-reversed; the code reverses the pointer as well
// RULE_07: Reverse needs select not 15, enable, increment
// RULE_08: Modifier is 15-bit field of reverse config
// RULE_09: Software aligns buffer start to its size
// RULE_10: Word data: modifier scaled, address bit 0 clear
// RULE_11: Byte writes or other forms give normal addresses
// RULE_12: Reverse adds modifier, ignores the mode offset
// RULE_13: Reverse beats modulo on writes, reads keep modulo
// RULE_14: Software avoids reverse read right after config write
// RULE_15: Modifier equals half the buffer size in words
// RULE_16: Sixteen-entry buffer follows 4-bit reversed index order
// RULE_17: Reverse-carry sum written back to the pointer
`include "abr_regs.svh"
module abr_agu (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // Core execution stage request
    input  wire logic             req_valid,
    input  wire logic             req_write,
    input  wire logic             req_byte,
    input  abr_pkg::abr_mode_t    req_mode,
    input  wire logic [3:0]       req_wreg,
    input  wire logic [15:0]      req_ptr,
    input  wire logic [15:0]      req_offs,
    // Address to data memory
    output logic                  ea_valid,
    output logic                  ea_write,
    output logic [15:0]           ea_addr,
    output logic                  rev_active,
    // Pointer write back to the register file
    output logic                  wb_en,
    output logic [3:0]            wb_reg,
    output logic [15:0]           wb_data
);
    // Software registers
    logic [15:0] modctl_reg;    // modulo_control_reg
    logic [15:0] mod_start_reg; // Modulo buffer start
    logic [15:0] mod_end_reg;   // Modulo buffer end
    logic [15:0] brcfg_reg;     // bit_reverse_config
    // APB answer flops
    logic        pready_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    // Core answer flops
    logic        ea_valid_reg;
    logic        ea_write_reg;
    logic [15:0] ea_addr_reg;
    logic        rev_active_reg;
    logic        wb_en_reg;
    logic [3:0]  wb_reg_reg;
    logic [15:0] wb_data_reg;

    // APB decode wires
    wire        apb_setup;
    wire        apb_done;
    wire        apb_wr;
    wire        hit_modctl;
    wire        hit_start;
    wire        hit_end;
    wire        hit_brcfg;
    wire        hit_lastea;
    wire        hit_any;
    wire [15:0] rd_word;

    // Field wires
    wire        mod_enable;
    wire [3:0]  mod_psel;
    wire [3:0]  reverse_pointer_select;
    wire        reverse_enable;
    wire [14:0] reverse_modifier;

    // Request decode wires
    wire        is_inc;
    wire        is_dec;
    wire        is_pre;
    wire        is_post;
    wire        is_ofs;
    wire        modifies;
    wire        walk_up;
    wire        mod_hit;
    wire        rev_act;
    wire [15:0] mod_sum;
    wire [15:0] corr_addr;
    wire [15:0] ptr_word;
    wire [15:0] rev_step;
    wire [15:0] rev_sum_r;
    wire [15:0] rev_sum;
    wire [15:0] ea_next;
    wire [15:0] wb_next;
    wire        wb_en_next;

    // Modulo paths, one per data direction
    abr_mod_if rd_if ();
    abr_mod_if wr_if ();

    // Bit order reversal of a 16-bit word
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // APB phase decode; answer comes one cycle after setup
    assign apb_setup  = psel & ~penable;
    assign apb_done   = psel & penable & pready_reg;
    assign apb_wr     = apb_done & pwrite;
    assign hit_modctl = paddr == `ABR_OFS_MODCTL;
    assign hit_start  = paddr == `ABR_OFS_MODSTART;
    assign hit_end    = paddr == `ABR_OFS_MODEND;
    assign hit_brcfg  = paddr == `ABR_OFS_BRCFG;
    assign hit_lastea = paddr == `ABR_OFS_LASTEA;
    assign hit_any    = hit_modctl | hit_start | hit_end | hit_brcfg | hit_lastea;

    // Read data mux; last address shows the block's own state
    assign rd_word = hit_modctl ? modctl_reg :
                     hit_start  ? mod_start_reg :
                     hit_end    ? mod_end_reg :
                     hit_brcfg  ? brcfg_reg :
                     hit_lastea ? ea_addr_reg :
                     `ABR_ZERO16;

    // Control fields
    assign mod_enable             = modctl_reg[`ABR_MC_MODEN];
    assign mod_psel               = modctl_reg[`ABR_MC_MSEL_HI:`ABR_MC_MSEL_LO];
    assign reverse_pointer_select = modctl_reg[`ABR_MC_RSEL_HI:`ABR_MC_RSEL_LO];
    assign reverse_enable         = brcfg_reg[`ABR_BR_EN];
    assign reverse_modifier       = brcfg_reg[`ABR_BR_MOD_HI:0]; // RULE_08

    // APB answer: ready one cycle after setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= apb_setup;
            prdata_reg  <= {16'h0000, rd_word};
            pslverr_reg <= apb_setup & ~hit_any;
        end
    end

    // Modulo control, reserved bits masked to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            modctl_reg <= `ABR_MC_RST;
        end else if (apb_wr && hit_modctl) begin
            modctl_reg <= pwdata[15:0] & `ABR_MC_MASK;
        end
    end

    // Modulo buffer bounds
    always_ff @(posedge clk) begin
        if (rst) begin
            mod_start_reg <= `ABR_ZERO16;
            mod_end_reg   <= `ABR_ZERO16;
        end else if (apb_wr) begin
            if (hit_start) begin
                mod_start_reg <= pwdata[15:0];
            end
            if (hit_end) begin
                mod_end_reg <= pwdata[15:0];
            end
        end
    end

    // Reverse configuration; software spaces reads after it
    always_ff @(posedge clk) begin
        if (rst) begin
            brcfg_reg <= `ABR_BR_RST;
        end else if (apb_wr && hit_brcfg) begin
            brcfg_reg <= pwdata[15:0]; // RULE_14
        end
    end

    // Addressing form decode
    assign is_inc   = req_mode == abr_pkg::AM_PREINC || req_mode == abr_pkg::AM_POSTINC;
    assign is_dec   = req_mode == abr_pkg::AM_PREDEC || req_mode == abr_pkg::AM_POSTDEC;
    assign is_pre   = req_mode == abr_pkg::AM_PREINC || req_mode == abr_pkg::AM_PREDEC;
    assign is_post  = req_mode == abr_pkg::AM_POSTINC || req_mode == abr_pkg::AM_POSTDEC;
    assign is_ofs   = req_mode == abr_pkg::AM_REGOFS;
    assign modifies = is_pre | is_post;
    // Direction of a register offset taken from its sign
    assign walk_up  = is_inc | (is_ofs & ~req_offs[15]);

    // Any working register may own the modulo buffer
    assign mod_hit = mod_enable & (req_wreg == mod_psel); // RULE_01

    // Reverse only for word writes with increment forms
    assign rev_act = reverse_enable & req_write & ~req_byte & is_inc
                   & (reverse_pointer_select != `ABR_NO_REV_PTR)
                   & (req_wreg == reverse_pointer_select); // RULE_07 RULE_05 RULE_11

    // Normal modified address
    assign mod_sum = is_dec ? 16'(req_ptr - req_offs) : 16'(req_ptr + req_offs);

    // Read path keeps modulo in all cases
    assign rd_if.addr_in  = mod_sum;
    assign rd_if.lo_bound = mod_start_reg;
    assign rd_if.hi_bound = mod_end_reg;
    assign rd_if.incr     = walk_up;
    assign rd_if.enable   = mod_hit & (modifies | is_ofs); // RULE_13

    // Write path loses modulo while reversing
    assign wr_if.addr_in  = mod_sum;
    assign wr_if.lo_bound = mod_start_reg;
    assign wr_if.hi_bound = mod_end_reg;
    assign wr_if.incr     = walk_up;
    assign wr_if.enable   = mod_hit & (modifies | is_ofs) & ~rev_act; // RULE_13

    // Modulo correctors
    abr_modulo u_rd_mod (
        .m (rd_if)
    );
    abr_modulo u_wr_mod (
        .m (wr_if)
    );

    // Pick the path of this access
    assign corr_addr = req_write ? wr_if.addr_out : rd_if.addr_out;

    // Pointer in normal order, word aligned
    assign ptr_word = {req_ptr[15:1], 1'b0}; // RULE_10
    // Modifier scaled to bytes; mode offset ignored
    assign rev_step = {reverse_modifier, 1'b0}; // RULE_10 RULE_12
    // Carry runs from the top bit downward
    assign rev_sum_r = 16'(rev16(ptr_word) + rev16(rev_step)); // RULE_06 RULE_17
    // Carry out of the bottom bit lands in bit 0; cleared so the walk wraps
    assign rev_sum   = rev16(rev_sum_r) & `ABR_WORD_MASK; // RULE_16 RULE_10

    // Effective address: pre and offset forms use the result
    assign ea_next = rev_act ? (is_pre ? rev_sum : ptr_word) :
                     (is_pre | is_ofs) ? corr_addr : req_ptr; // RULE_04

    // Pointer update: modify forms only
    assign wb_next    = rev_act ? rev_sum : corr_addr; // RULE_17
    assign wb_en_next = req_valid & modifies; // RULE_03 RULE_04

    // Core answer registered one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            ea_valid_reg   <= 1'b0;
            rev_active_reg <= 1'b0;
            wb_en_reg      <= 1'b0;
        end else begin
            ea_valid_reg   <= req_valid;
            rev_active_reg <= req_valid & rev_act;
            wb_en_reg      <= wb_en_next;
        end
    end

    // Address and data held with the request's valid
    always_ff @(posedge clk) begin
        if (rst) begin
            ea_write_reg <= 1'b0;
            ea_addr_reg  <= `ABR_ZERO16;
            wb_reg_reg   <= 4'h0;
            wb_data_reg  <= `ABR_ZERO16;
        end else if (req_valid) begin
            ea_write_reg <= req_write;
            ea_addr_reg  <= ea_next;
            wb_reg_reg   <= req_wreg;
            wb_data_reg  <= wb_next;
        end
    end

    // Outputs straight from flops
    assign pready     = pready_reg;
    assign prdata     = prdata_reg;
    assign pslverr    = pslverr_reg;
    assign ea_valid   = ea_valid_reg;
    assign ea_write   = ea_write_reg;
    assign ea_addr    = ea_addr_reg;
    assign rev_active = rev_active_reg;
    assign wb_en      = wb_en_reg;
    assign wb_reg     = wb_reg_reg;
    assign wb_data    = wb_data_reg;

    // Helper: request stays inside the modulo buffer
    wire in_buf_req = req_valid & mod_hit & ~rev_act & modifies
                    & (req_ptr >= mod_start_reg) & (req_ptr <= mod_end_reg)
                    & (req_offs <= 16'h0002);

    // APB handshake steps
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_access_s;
        psel && penable && pready;
    endsequence

    // Reverse request steps
    sequence rev_pre_s;
        req_valid && rev_act && req_mode == abr_pkg::AM_PREINC;
    endsequence

    apb_ready_a: assert property (@(posedge clk) disable iff (rst)
        apb_setup_s |=> apb_access_s ##1 !pready)
        else $error("APB answer not one cycle after setup");

    brcfg_write_a: assert property (@(posedge clk) disable iff (rst) // RULE_08
        apb_access_s ##0 (pwrite && hit_brcfg)
        |=> reverse_modifier == $past(pwdata[14:0]))
        else $error("Reverse modifier not taken from config write");

    ofs_keep_ptr_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
        req_valid && req_mode == abr_pkg::AM_REGOFS |=> !wb_en)
        else $error("Offset form wrote the pointer back");

    ind_plain_a: assert property (@(posedge clk) disable iff (rst) // RULE_03
        req_valid && req_mode == abr_pkg::AM_IND
        |=> !wb_en && ea_addr == $past(req_ptr))
        else $error("Plain indirect changed pointer or address");

    stack_no_rev_a: assert property (@(posedge clk) disable iff (rst) // RULE_07
        req_valid && reverse_pointer_select == `ABR_NO_REV_PTR |=> !rev_active)
        else $error("Reverse used with stack pointer select");

    byte_no_rev_a: assert property (@(posedge clk) disable iff (rst) // RULE_11
        req_valid && (req_byte || !req_write) |=> !rev_active)
        else $error("Reverse used on byte or read access");

    rev_pre_ea_a: assert property (@(posedge clk) disable iff (rst) // RULE_10
        rev_pre_s |=> wb_en && rev_active && !ea_addr[0] && wb_data == ea_addr)
        else $error("Reverse pre-increment address wrong");

    rev_ignore_ofs_a: assert property (@(posedge clk) disable iff (rst) // RULE_12
        req_valid && rev_act && req_mode == abr_pkg::AM_POSTINC
        |=> ea_addr == $past(ptr_word) && wb_data == $past(rev_sum))
        else $error("Reverse post-increment used mode offset");

    mod_inside_a: assert property (@(posedge clk) disable iff (rst) // RULE_02
        in_buf_req |=> wb_data >= mod_start_reg && wb_data <= mod_end_reg)
        else $error("Modulo result left the buffer");

    rd_mod_kept_a: assert property (@(posedge clk) disable iff (rst) // RULE_13
        req_valid && !req_write && mod_hit && modifies |=> wb_data == $past(rd_if.addr_out))
        else $error("Read path lost modulo correction");
endmodule

/* verilog/abr_mod_if.sv */
// Signals between the address generator and a modulo corrector.
// Assumes a purely combinational corrector on the far side.
interface abr_mod_if;
    logic [15:0] addr_in;   // Raw modified address
    logic [15:0] lo_bound;  // Buffer start address
    logic [15:0] hi_bound;  // Buffer end address
    logic        incr;      // Buffer walks upward
    logic        enable;    // Correction allowed
    logic [15:0] addr_out;  // Corrected address
    // Corrector side
    modport unit (input addr_in, lo_bound, hi_bound, incr, enable,
                  output addr_out);
    // Generator side
    modport user (output addr_in, lo_bound, hi_bound, incr, enable,
                  input addr_out);
endinterface

/* verilog/abr_modulo.sv */
// Modulo (circular buffer) correction for one address path.
// Assumes lo_bound <= hi_bound; purely combinational, no clock.
module abr_modulo (
    // Link to the address generator
    abr_mod_if.unit m
);
    // Buffer length in bytes, end address inclusive
    wire [15:0] buf_len;
    wire        past_hi;
    wire        past_lo;
    wire        wrap_dn;
    wire        wrap_up;

    assign buf_len = 16'(m.hi_bound - m.lo_bound + 16'h0001);
    // Beyond, not only equal: a big step still wraps
    assign past_hi = m.addr_in > m.hi_bound; // RULE_02
    assign past_lo = m.addr_in < m.lo_bound; // RULE_02
    // Upper bound for rising buffers, lower for falling ones
    assign wrap_dn = m.enable & m.incr & past_hi; // RULE_01
    assign wrap_up = m.enable & ~m.incr & past_lo; // RULE_01
    // Selection of the corrected address
    assign m.addr_out = wrap_dn ? 16'(m.addr_in - buf_len) :
                        wrap_up ? 16'(m.addr_in + buf_len) :
                        m.addr_in;
endmodule

/* verilog/abr_pkg.sv */
// Types shared by the AGU modules.
// Assumes the register constants come from abr_regs.svh.
package abr_pkg;
    // Addressing form of the current request
    typedef enum logic [2:0] {
        AM_IND     = 3'b000,  // Plain register indirect
        AM_POSTINC = 3'b001,  // Post-increment
        AM_POSTDEC = 3'b010,  // Post-decrement
        AM_PREINC  = 3'b011,  // Pre-increment
        AM_PREDEC  = 3'b100,  // Pre-decrement
        AM_REGOFS  = 3'b101   // Register plus offset
    } abr_mode_t;
endpackage

/* verilog/abr_regs.svh */
// Register offsets, field positions and reset values of the AGU block.
// Assumes byte addresses on a 12-bit APB address, one word per register.
`ifndef ABR_REGS_SVH
`define ABR_REGS_SVH
// Register byte offsets
`define ABR_OFS_MODCTL   12'h000
`define ABR_OFS_MODSTART 12'h004
`define ABR_OFS_MODEND   12'h008
`define ABR_OFS_BRCFG    12'h00C
`define ABR_OFS_LASTEA   12'h010
// Modulo control fields
`define ABR_MC_MODEN     15
`define ABR_MC_RSEL_HI   7
`define ABR_MC_RSEL_LO   4
`define ABR_MC_MSEL_HI   3
`define ABR_MC_MSEL_LO   0
`define ABR_MC_MASK      16'h80FF
`define ABR_MC_RST       16'h00F0
// Reverse configuration fields
`define ABR_BR_EN        15
`define ABR_BR_MOD_HI    14
`define ABR_BR_RST       16'h0000
// Word addresses only: bit 0 of a reversed result is dropped
`define ABR_WORD_MASK    16'hFFFE
// Pointer select that never reverses (stack pointer)
`define ABR_NO_REV_PTR   4'hF
// Plain reset value for data registers
`define ABR_ZERO16       16'h0000
`endif
